// ===== hw/mrmc_top.sv
// Receive mode control of an Ethernet MAC with length check, filtering, pause and loopback.
//
// Functional notes
// R1: Software writes the mode register only while the controller is disabled.
// R2: Frame length limit sits in bits 26 to 16 and resets to 1518.
// R3: Length counts from first destination byte through the CRC inclusive.
// R4: A transmit frame above the limit raises the transmit oversize event.
// R5: A receive frame above the limit raises its event and the long-frame flag.
// R6: Software should program 1518, or 1522 for tagged frames.
// R7: With bit 5 set, received pause frames stop data transmission for their time.
// R8: With bit 4 set, frames to the all-ones address are rejected.
// R9: With bit 3 set, every received frame is accepted; the code still rejects frames to the all-ones address when bit 4 is also set.
// R10: Bit 2 selects serial seven-wire mode at 0 or MII mode at 1.
// R11: Bit 1 set blocks reception while transmitting; clear lets both run. The code drops only frames whose reception starts while tx_busy is set.
// R12: Loopback returns transmitted frames to receive and keeps transmit pins low.
// R13: In loopback the transmit path is timed from the internal clock.
// R14: Software keeps bit 1 clear whenever loopback is enabled.
// R15: Software writes zeros to bits 31 to 27 and 15 to 6.
// R16: Otherwise frames are accepted by normal destination address recognition.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mrmc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    input  wire logic [47:0] station_addr_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_last_i,
    output logic             tx_ready_o,
    input  wire logic        external_tx_clock_i,
    output logic      [3:0]  txd_o,
    output logic             tx_en_o,
    input  wire logic        rx_clk_i,
    input  wire logic        rx_dv_i,
    input  wire logic [3:0]  rxd_i,
    output logic             rx_done_o,
    output logic             rx_accept_o,
    output logic             long_frame_flag_o,
    output logic             tx_oversize_event_o,
    output logic             rx_oversize_event_o
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic [1:0] clk_prev_ff;
    logic       dv_prev_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            clk_prev_ff <= '0;
            dv_prev_ff  <= 1'b0;
        end else begin
            sync1_ff    <= {external_tx_clock_i, rx_clk_i, rx_dv_i, rxd_i};
            sync2_ff    <= sync1_ff;
            clk_prev_ff <= sync2_ff[6:5];
            dv_prev_ff  <= sync2_ff[4];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    mrmc_pkg::mrmc_mode_type mode_ff;
    mrmc_pkg::mrmc_mode_type nxt_mode;
    logic                    enable_ff;
    logic                    nxt_enable;
    logic [31:0]             nxt_rd_data;
    logic                    paused_ff;
    logic                    tx_busy;
    logic                    rx_busy_ff;

    always_comb begin
        nxt_mode    = mode_ff;
        nxt_enable  = enable_ff;
        nxt_rd_data = 32'h0000_0000;
        if (wr_i && (addr_i == mrmc_pkg::ADDR_RX_MODE_CONFIG)) begin
            nxt_mode = mrmc_pkg::mrmc_mode_type'(wr_data_i & mrmc_pkg::RMC_WRITE_MASK); // [R15]
        end
        if (wr_i && (addr_i == mrmc_pkg::ADDR_CONTROL)) begin
            nxt_enable = wr_data_i[mrmc_pkg::CTRL_ENABLE_BIT];
        end
        if (rd_i) begin
            case (addr_i)
                mrmc_pkg::ADDR_RX_MODE_CONFIG: nxt_rd_data = 32'(mode_ff);
                mrmc_pkg::ADDR_CONTROL:        nxt_rd_data = {31'h0, enable_ff};
                mrmc_pkg::ADDR_STATUS:         nxt_rd_data = {29'h0, rx_busy_ff, tx_busy,
                                                              paused_ff};
                default:                       nxt_rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_ff                    <= '0;
            mode_ff.frame_length_limit <= mrmc_pkg::LIMIT_RESET; // [R2]
            enable_ff                  <= 1'b0;
            rd_data_o                  <= 32'h0000_0000;
        end else begin
            mode_ff   <= nxt_mode;
            enable_ff <= nxt_enable;
            rd_data_o <= nxt_rd_data;
        end
    end

    // ****************************************************************
    // Transmit timing
    // ****************************************************************
    logic [3:0] div_ff;
    logic [3:0] nxt_div;
    logic       tx_tick;

    always_comb begin
        nxt_div = (div_ff == 4'(mrmc_pkg::LOOP_TICK_CYC - 1)) ? 4'h0 : div_ff + 4'h1;
        tx_tick = enable_ff && (mode_ff.loopback ? (div_ff == 4'h0) // [R13]
                                : (sync2_ff[6] && !clk_prev_ff[1]));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // ****************************************************************
    // Transmit engine
    // ****************************************************************
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_STOP} mrmc_tx_state_type;
    mrmc_tx_state_type tx_st_ff;
    mrmc_tx_state_type nxt_tx_st;
    logic [7:0]        tx_byte_ff;
    logic [7:0]        nxt_tx_byte;
    logic [2:0]        tx_ph_ff;
    logic [2:0]        nxt_tx_ph;
    logic              tx_last_ff;
    logic              nxt_tx_last;
    logic [3:0]        nxt_txd;
    logic              nxt_tx_en;
    logic              nxt_ready;
    logic [3:0]        tx_piece;
    logic              piece_end;
    mrmc_pkg::mrmc_sym_type lb_sym;

    always_comb begin
        nxt_tx_st   = tx_st_ff;
        nxt_tx_byte = tx_byte_ff;
        nxt_tx_ph   = tx_ph_ff;
        nxt_tx_last = tx_last_ff;
        nxt_txd     = txd_o;
        nxt_tx_en   = tx_en_o;
        nxt_ready   = 1'b0;
        tx_piece    = mode_ff.mii_mode ? (tx_ph_ff[0] ? tx_byte_ff[7:4] : tx_byte_ff[3:0])
                                       : {3'h0, tx_byte_ff[tx_ph_ff]}; // [R10]
        piece_end   = mode_ff.mii_mode ? tx_ph_ff[0] : (tx_ph_ff == 3'h7);
        lb_sym      = '0;
        case (tx_st_ff)
            TX_IDLE: begin
                if (enable_ff && tx_valid_i && !paused_ff) begin // [R7]
                    nxt_tx_st   = TX_SEND;
                    nxt_tx_byte = tx_data_i;
                    nxt_tx_last = tx_last_i;
                    nxt_tx_ph   = 3'h0;
                    nxt_ready   = 1'b1;
                end
            end
            TX_SEND: begin
                if (tx_tick) begin
                    nxt_txd     = mode_ff.loopback ? 4'h0 : tx_piece; // [R12]
                    nxt_tx_en   = !mode_ff.loopback;
                    lb_sym.step = mode_ff.loopback;
                    lb_sym.data = tx_piece;
                    nxt_tx_ph   = tx_ph_ff + 3'h1;
                    if (piece_end) begin
                        nxt_tx_ph = 3'h0;
                        if (tx_last_ff || !tx_valid_i) begin
                            nxt_tx_st = TX_STOP;
                        end else begin
                            nxt_tx_byte = tx_data_i;
                            nxt_tx_last = tx_last_i;
                            nxt_ready   = 1'b1;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    nxt_txd     = 4'h0;
                    nxt_tx_en   = 1'b0;
                    lb_sym.stop = mode_ff.loopback;
                    nxt_tx_st   = TX_IDLE;
                end
            end
            default: nxt_tx_st = TX_IDLE;
        endcase
        if (!enable_ff) begin
            nxt_tx_st = TX_IDLE;
            nxt_txd   = 4'h0;
            nxt_tx_en = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_st_ff   <= TX_IDLE;
            tx_byte_ff <= 8'h00;
            tx_ph_ff   <= 3'h0;
            tx_last_ff <= 1'b0;
            txd_o      <= 4'h0;
            tx_en_o    <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            tx_st_ff   <= nxt_tx_st;
            tx_byte_ff <= nxt_tx_byte;
            tx_ph_ff   <= nxt_tx_ph;
            tx_last_ff <= nxt_tx_last;
            txd_o      <= nxt_txd;
            tx_en_o    <= nxt_tx_en;
            tx_ready_o <= nxt_ready;
        end
    end

    assign tx_busy = (tx_st_ff != TX_IDLE);

    mrmc_len_check u_tx_len (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .clear_i      (!tx_busy),
        .byte_i       (nxt_ready), // [R3]
        .limit_i      (mode_ff.frame_length_limit),
        .over_o       (),
        .over_pulse_o (tx_oversize_event_o) // [R4]
    );

    // ****************************************************************
    // Receive engine
    // ****************************************************************
    mrmc_pkg::mrmc_sym_type rx_sym;
    logic [7:0]  hdr_ff [mrmc_pkg::HDR_BYTES];
    logic [7:0]  nxt_hdr [mrmc_pkg::HDR_BYTES];
    logic [7:0]  rx_sh_ff;
    logic [7:0]  nxt_rx_sh;
    logic [2:0]  rx_ph_ff;
    logic [2:0]  nxt_rx_ph;
    logic [4:0]  rx_idx_ff;
    logic [4:0]  nxt_rx_idx;
    logic        rx_drop_ff;
    logic        nxt_rx_drop;
    logic        nxt_rx_busy;
    logic        rx_byte;
    logic        rx_over;
    logic        nxt_done;
    logic        nxt_accept;
    logic        nxt_long;
    logic [47:0] da;
    logic        is_bcast;
    logic        is_pause;
    logic [24:0] pause_bits_ff;
    logic [24:0] nxt_pause_bits;

    always_comb begin
        rx_sym      = lb_sym;
        if (!mode_ff.loopback) begin
            rx_sym.step = enable_ff && sync2_ff[5] && !clk_prev_ff[0] && sync2_ff[4];
            rx_sym.stop = enable_ff && dv_prev_ff && !sync2_ff[4];
            rx_sym.data = sync2_ff[3:0];
        end
        nxt_hdr     = hdr_ff;
        nxt_rx_sh   = rx_sh_ff;
        nxt_rx_ph   = rx_ph_ff;
        nxt_rx_idx  = rx_idx_ff;
        nxt_rx_drop = rx_drop_ff;
        nxt_rx_busy = rx_busy_ff;
        rx_byte     = 1'b0;
        nxt_done    = 1'b0;
        nxt_accept  = rx_accept_o;
        nxt_long    = long_frame_flag_o;
        for (int i = 0; i < 6; i++) begin
            da[47 - 8*i -: 8] = hdr_ff[i];
        end
        is_bcast = (da == 48'hffff_ffff_ffff);
        is_pause = (da == mrmc_pkg::PAUSE_DA) && ({hdr_ff[12], hdr_ff[13]} ==
                   mrmc_pkg::PAUSE_TYPE) && ({hdr_ff[14], hdr_ff[15]} == mrmc_pkg::PAUSE_OPCODE);
        nxt_pause_bits = pause_bits_ff;
        if (tx_tick && (pause_bits_ff != '0)) begin
            nxt_pause_bits = (mode_ff.mii_mode && pause_bits_ff > 25'h3)
                             ? pause_bits_ff - 25'h4 : pause_bits_ff - 25'h1;
        end
        if (rx_sym.step) begin
            if (!rx_busy_ff) begin
                nxt_rx_busy = 1'b1;
                nxt_rx_drop = mode_ff.rx_block_during_tx && tx_busy; // [R11]
                nxt_rx_idx  = 5'h0;
                nxt_rx_ph   = 3'h0;
            end
            if (mode_ff.mii_mode) begin
                nxt_rx_sh = {rx_sym.data, rx_sh_ff[7:4]};
                rx_byte   = nxt_rx_ph[0];
            end else begin
                nxt_rx_sh = {rx_sym.data[0], rx_sh_ff[7:1]};
                rx_byte   = (nxt_rx_ph == 3'h7);
            end
            nxt_rx_ph = nxt_rx_ph + 3'h1;
            if (rx_byte && (nxt_rx_idx < 5'(mrmc_pkg::HDR_BYTES))) begin
                nxt_hdr[nxt_rx_idx] = nxt_rx_sh;
                nxt_rx_idx          = nxt_rx_idx + 5'h1;
            end
        end else if (rx_sym.stop && rx_busy_ff) begin
            nxt_rx_busy = 1'b0;
            if (!rx_drop_ff) begin
                nxt_done   = 1'b1;
                nxt_long   = rx_over; // [R5]
                nxt_accept = (is_bcast && mode_ff.broadcast_drop) ? 1'b0 // [R8]
                           : mode_ff.accept_all_frames ? 1'b1 // [R9]
                           : (is_bcast || da == station_addr_i); // [R16]
                if (mode_ff.pause_honor_enable && is_pause &&
                    (rx_idx_ff == 5'(mrmc_pkg::HDR_BYTES))) begin // [R7]
                    nxt_pause_bits = 25'({hdr_ff[16], hdr_ff[17]}) *
                                     25'(mrmc_pkg::PAUSE_QUANTUM);
                end
            end
        end
        if (!enable_ff) begin
            nxt_rx_busy    = 1'b0;
            nxt_pause_bits = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hdr_ff            <= '{default: 8'h00};
            rx_sh_ff          <= 8'h00;
            rx_ph_ff          <= 3'h0;
            rx_idx_ff         <= 5'h0;
            rx_drop_ff        <= 1'b0;
            rx_busy_ff        <= 1'b0;
            rx_done_o         <= 1'b0;
            rx_accept_o       <= 1'b0;
            long_frame_flag_o <= 1'b0;
            pause_bits_ff     <= '0;
            paused_ff         <= 1'b0;
        end else begin
            hdr_ff            <= nxt_hdr;
            rx_sh_ff          <= nxt_rx_sh;
            rx_ph_ff          <= nxt_rx_ph;
            rx_idx_ff         <= nxt_rx_idx;
            rx_drop_ff        <= nxt_rx_drop;
            rx_busy_ff        <= nxt_rx_busy;
            rx_done_o         <= nxt_done;
            rx_accept_o       <= nxt_accept;
            long_frame_flag_o <= nxt_long;
            pause_bits_ff     <= nxt_pause_bits;
            paused_ff         <= (nxt_pause_bits != '0);
        end
    end

    mrmc_len_check u_rx_len (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .clear_i      (!rx_busy_ff || rx_drop_ff),
        .byte_i       (rx_byte), // [R3]
        .limit_i      (mode_ff.frame_length_limit),
        .over_o       (rx_over),
        .over_pulse_o (rx_oversize_event_o) // [R5]
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic saw_over_ff;

    // Remembers a receive oversize event until the frame that caused it has ended.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            saw_over_ff <= 1'b0;
        end else begin
            saw_over_ff <= rx_oversize_event_o || (saw_over_ff && rx_busy_ff);
        end
    end

    AST_LIMIT_RESET: assert property (@(posedge clk_i) $rose(rst_n_i) |->  // [R2]
        mode_ff.frame_length_limit == 11'h5ee) else $error("limit reset value wrong");
    AST_LOOP_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
        $past(mode_ff.loopback) && mode_ff.loopback |-> !tx_en_o && txd_o == 4'h0)
        else $error("transmit pins active in loopback");
    AST_PAUSE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
        paused_ff && tx_st_ff == TX_IDLE |=> tx_st_ff == TX_IDLE)
        else $error("frame started during pause");
    AST_BCAST_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        nxt_done && is_bcast && mode_ff.broadcast_drop |=> !rx_accept_o)
        else $error("broadcast accepted while dropped");
    AST_PROMISC: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        nxt_done && mode_ff.accept_all_frames && !mode_ff.broadcast_drop |=> rx_accept_o)
        else $error("frame rejected in accept-all mode");
    AST_BLOCK_RX: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        rx_sym.step && !rx_busy_ff && tx_busy && mode_ff.rx_block_during_tx
        |=> rx_drop_ff) else $error("reception not blocked during transmit");
    AST_LOOP_TICK: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
        mode_ff.loopback && enable_ff && tx_tick
        |-> ##8 (tx_tick || !enable_ff || !mode_ff.loopback))
        else $error("loopback tick missing");
    AST_RX_LONG: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
        rx_done_o |-> long_frame_flag_o == saw_over_ff)
        else $error("long flag disagrees with oversize event");
    AST_TX_OVER: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
        tx_oversize_event_o |-> tx_busy || $past(tx_busy))
        else $error("transmit oversize outside a frame");

endmodule : mrmc_top

// ===== hw/mrmc_pkg.sv
// Package with register map, field layout and timing constants of the receive mode block.
package mrmc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  ADDR_RX_MODE_CONFIG = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL        = 8'h04;
    localparam logic [7:0]  ADDR_STATUS         = 8'h08;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          LIMIT_LSB       = 16;
    localparam int          LIMIT_W         = 11;
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam logic [10:0] LIMIT_RESET     = 11'h5ee;
    localparam logic [31:0] RMC_WRITE_MASK  = 32'h07ff_003f;

    // ****************************************************************
    // Frame and timing constants
    // ****************************************************************
    localparam int          LEN_W           = 12;
    localparam int          HDR_BYTES       = 18;
    localparam int          LOOP_TICK_NS    = 400;
    localparam int          CLK_NS          = 50;
    localparam int          LOOP_TICK_CYC   = LOOP_TICK_NS / CLK_NS;
    localparam int          PAUSE_QUANTUM   = 512;
    localparam logic [47:0] PAUSE_DA        = 48'h0180_c200_0001;
    localparam logic [15:0] PAUSE_TYPE      = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE    = 16'h0001;

    // Software-visible mode register, bit 31 down to bit 0.
    typedef struct packed {
        logic [4:0]  rsv_hi;
        logic [10:0] frame_length_limit;
        logic [9:0]  rsv_lo;
        logic        pause_honor_enable;
        logic        broadcast_drop;
        logic        accept_all_frames;
        logic        mii_mode;
        logic        rx_block_during_tx;
        logic        loopback;
    } mrmc_mode_type;

    // One symbol step on the receive side, from pins or from loopback.
    typedef struct packed {
        logic       step;
        logic       stop;
        logic [3:0] data;
    } mrmc_sym_type;

endpackage : mrmc_pkg

// ===== hw/mrmc_len_check.sv
// Frame byte counter that flags a frame longer than the programmed limit.
`timescale 1ns/1ps
module mrmc_len_check #(
    parameter int LEN_W = mrmc_pkg::LEN_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clear_i,
    input  wire logic              byte_i,
    input  wire logic [10:0]       limit_i,
    output logic                   over_o,
    output logic                   over_pulse_o
);
    logic [LEN_W-1:0] count_ff;
    logic [LEN_W-1:0] nxt_count;
    logic             over_ff;
    logic             nxt_over;
    logic             pulse_ff;
    logic             nxt_pulse;

    always_comb begin
        nxt_count = clear_i ? '0 : count_ff;
        nxt_over  = clear_i ? 1'b0 : over_ff;
        nxt_pulse = 1'b0;
        // A byte in the clearing cycle is the first byte of a new frame.
        if (byte_i && (nxt_count != '1)) begin
            nxt_count = nxt_count + LEN_W'(1);
            if ((nxt_count > LEN_W'(limit_i)) && !nxt_over) begin
                nxt_over  = 1'b1;
                nxt_pulse = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_ff <= '0;
            over_ff  <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            over_ff  <= nxt_over;
            pulse_ff <= nxt_pulse;
        end
    end

    assign over_o       = over_ff;
    assign over_pulse_o = pulse_ff;

endmodule : mrmc_len_check

// ===== test/mrmc_phy_model.sv
// Link partner model that drives the receive pins and the transmit clock.
`timescale 1ns/1ps
module mrmc_phy_model (
    output logic       rx_clk_o,
    output logic       rx_dv_o,
    output logic [3:0] rxd_o,
    output logic       tx_clk_o
);
    initial begin
        rx_clk_o = 1'b0;
        rx_dv_o  = 1'b0;
        rxd_o    = 4'h5;
        tx_clk_o = 1'b0;
    end
    always #200 tx_clk_o = ~tx_clk_o;
    // Sends a frame; outside frames the clock stands still and data show stale inverse values.
    task automatic send(input logic [7:0] fr[$], input logic mii);
        for (int i = 0; i < fr.size() * (mii ? 2 : 8); i++) begin
            rxd_o   = mii ? fr[i/2][4*(i%2)+:4] : {3'h0, fr[i/8][i%8]};
            rx_dv_o = 1'b1;
            #200 rx_clk_o = 1'b1;
            #200 rx_clk_o = 1'b0;
        end
        rx_dv_o = 1'b0;
        rxd_o   = ~rxd_o;
        #800;
    endtask : send
endmodule : mrmc_phy_model

// ===== test/mrmc_top_tb.sv
// Self-checking testbench of the receive mode control block.
`timescale 1ns/1ps
module mrmc_top_tb;
    localparam logic [47:0] STA = 48'h0200_0000_0001;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rd_data_o;
    logic [7:0]  tx_data_i = 8'h00;
    logic        tx_valid_i = 1'b0;
    logic        tx_last_i = 1'b0;
    logic        tx_ready_o, tx_en_o, tx_clk, rx_clk, rx_dv, seen_en;
    logic [3:0]  txd_o, rxd;
    logic        rx_done_o, rx_accept_o, long_frame_flag_o, tx_oversize_event_o;
    logic        rx_oversize_event_o;
    logic [7:0]  fr[$];
    int          errors, n_checks, n_done, n_rxo, n_txo, cyc;
    always #25 clk_i = ~clk_i;
    mrmc_top mrmc_top_inst (.clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
        .station_addr_i(STA), .tx_data_i, .tx_valid_i, .tx_last_i, .tx_ready_o,
        .external_tx_clock_i(tx_clk), .txd_o, .tx_en_o, .rx_clk_i(rx_clk), .rx_dv_i(rx_dv),
        .rxd_i(rxd), .rx_done_o, .rx_accept_o, .long_frame_flag_o, .tx_oversize_event_o,
        .rx_oversize_event_o);
    mrmc_phy_model mrmc_phy_model_inst (.rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rxd_o(rxd),
        .tx_clk_o(tx_clk));
    always @(posedge clk_i) begin
        cyc++;
        if (rx_done_o === 1'b1) n_done++;
        if (rx_oversize_event_o === 1'b1) n_rxo++;
        if (tx_oversize_event_o === 1'b1) n_txo++;
        if (tx_en_o === 1'b1) seen_en = 1'b1;
        if (cyc == 40000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask : rd
    function automatic logic [31:0] md(input logic [5:0] b);
        return {5'h00, 11'h040, 10'h000, b};
    endfunction : md
    task automatic cfg(input logic [31:0] m);
        wr(mrmc_pkg::ADDR_CONTROL, 32'h0);
        wr(mrmc_pkg::ADDR_RX_MODE_CONFIG, m);
        wr(mrmc_pkg::ADDR_CONTROL, 32'h1);
    endtask : cfg
    task automatic mk(input logic [47:0] da, input int n);
        logic [47:0] pw;
        pw = {mrmc_pkg::PAUSE_TYPE, mrmc_pkg::PAUSE_OPCODE, 16'h0001};
        fr = {};
        for (int i = 0; i < n; i++) begin
            fr.push_back(i < 6 ? da[47-8*i-:8] : (i > 11 && i < 18) ? pw[143-8*i-:8] : 8'h00);
        end
    endtask : mk
    task automatic tx();
        int k;
        for (int i = 0; i < fr.size(); i++) begin
            tx_data_i  <= fr[i];
            tx_valid_i <= 1'b1;
            tx_last_i  <= (i == fr.size() - 1);
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (tx_ready_o !== 1'b1 && k < 2000);
            if (k == 2000) errors++;
        end
        tx_valid_i <= 1'b0;
    endtask : tx
    task automatic t_regs();
        logic [31:0] v;
        rd(mrmc_pkg::ADDR_RX_MODE_CONFIG, v);
        chk(v, 32'(mrmc_pkg::LIMIT_RESET) << mrmc_pkg::LIMIT_LSB);
        rd(8'h0c, v);
        chk(v, 32'h0);
        wr(mrmc_pkg::ADDR_RX_MODE_CONFIG, 32'h05f2_003c);
        rd(mrmc_pkg::ADDR_RX_MODE_CONFIG, v);
        chk(v, 32'h05f2_003c);
        $display("register test done");
    endtask : t_regs
    task automatic t_rx(input logic [5:0] b, input logic [47:0] da, input int n,
                        input logic acc, input logic lg);
        int d0;
        int o0;
        cfg(md(b));
        mk(da, n);
        d0 = n_done;
        o0 = n_rxo;
        mrmc_phy_model_inst.send(fr, b[2]);
        repeat (20) @(posedge clk_i);
        chk({8'(n_done - d0), 8'(n_rxo - o0), 6'h0, rx_accept_o, long_frame_flag_o},
            {8'h1, 7'h0, lg, 6'h0, acc, lg});
        $display("receive test done");
    endtask : t_rx
    task automatic t_loop();
        int d0;
        int r0;
        int t0;
        cfg(md(6'h05));
        mk(STA, 65);
        seen_en = 1'b0;
        d0 = n_done;
        r0 = n_rxo;
        t0 = n_txo;
        tx();
        repeat (40) @(posedge clk_i);
        chk({8'(n_done - d0), 8'(n_rxo - r0), 8'(n_txo - t0), 6'h0, seen_en, rx_accept_o},
            32'h0101_0101);
        $display("loopback test done");
    endtask : t_loop
    task automatic t_drt(input logic b);
        int d0;
        cfg(md({3'h0, 1'b1, b, 1'b0}));
        mk(STA, 64);
        seen_en = 1'b0;
        d0 = n_done;
        fork
            tx();
            #3000 mrmc_phy_model_inst.send(fr, 1'b1);
        join
        repeat (40) @(posedge clk_i);
        chk({seen_en, 8'(n_done - d0)}, {1'b1, 7'h0, !b});
        $display("receive during transmit test done");
    endtask : t_drt
    task automatic t_pause(input logic f);
        logic [31:0] s;
        int c0;
        cfg(md({f, 5'h04}));
        mk(mrmc_pkg::PAUSE_DA, 64);
        mrmc_phy_model_inst.send(fr, 1'b1);
        repeat (20) @(posedge clk_i);
        rd(mrmc_pkg::ADDR_STATUS, s);
        chk(s[0], f);
        fr = {8'h55};
        c0 = cyc;
        tx();
        chk(cyc - c0 > 500, f);
        $display("pause test done");
    endtask : t_pause
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_rx(6'h04, STA, 64, 1'b1, 1'b0);
        t_rx(6'h04, 48'h0200_0000_0002, 64, 1'b0, 1'b0);
        t_rx(6'h04, 48'hffff_ffff_ffff, 64, 1'b1, 1'b0);
        t_rx(6'h14, 48'hffff_ffff_ffff, 64, 1'b0, 1'b0);
        t_rx(6'h0c, 48'h0200_0000_0002, 64, 1'b1, 1'b0);
        t_rx(6'h00, STA, 64, 1'b1, 1'b0);
        t_rx(6'h04, STA, 65, 1'b1, 1'b1);
        t_loop();
        t_drt(1'b0);
        t_drt(1'b1);
        t_pause(1'b0);
        t_pause(1'b1);
        results();
    end
endmodule : mrmc_top_tb
